// ### inc/cfc_defs.vh
// Purpose: Constants of the channel format converter
// Assumes: Included by every converter file
// Notes: Format, width, field and scale codes
//
// Summary of operation
// - Unsigned normalized code over all-ones gives fraction
// - Gamma flag only with unsigned normalized
// - Inverse gamma on fetch, forward before store
// - Signed normalized code over half-range minus one
// - Most negative signed code clamps to minus one
// - Unsigned integer copy, zero extended
// - Unsigned integer to float, nearest even
// - Signed integer copy, sign extended
// - Signed integer to float, nearest even
// - Single precision fields, bias, special classes
// - Double precision fields, bias, special classes
// - Half precision fields, bias, special classes
// - Single exponents map onto half range
// - Narrowing to half rounds nearest even, flushes below denormal range
`ifndef CFC_DEFS_VH
`define CFC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Format selector codes
`define CFC_FMT_UNSIGNED_NORMALIZED 4'h0
`define CFC_FMT_SIGNED_NORMALIZED 4'h1
`define CFC_FMT_UNSIGNED_INTEGER_COPY 4'h2
`define CFC_FMT_UNSIGNED_SCALED_TO_FLOAT 4'h3
`define CFC_FMT_SIGNED_INTEGER_COPY 4'h4
`define CFC_FMT_SIGNED_SCALED_TO_FLOAT 4'h5
`define CFC_FMT_F32 4'h6
`define CFC_FMT_F64 4'h7
`define CFC_FMT_F16 4'h8
`define CFC_FMT_F32TO16 4'h9

// Channel width codes
`define CFC_W8 2'h0
`define CFC_W16 2'h1
`define CFC_W32 2'h2

////////////////////////////////////////////////////////////////////////////////
// Float field limits and offsets
`define CFC_F32_BIAS 10'h07F
`define CFC_F32_EMAX 8'hFF
`define CFC_F16_EMAX 5'h1F
`define CFC_F64_EMAX 11'h7FF
`define CFC_F16_TO_F32 8'h70
`define CFC_H_MIN_EXP 8'h71
`define CFC_H_MAX_EXP 8'h8E
`define CFC_H_DEN_EXP 8'h67
`define CFC_H_DEN_SHF 8'h7E
`define CFC_NEG_ONE 32'hBF800000
`define CFC_F32_QNAN 23'h400000
`define CFC_F16_QNAN 10'h200

// Normalizer scale values
`define CFC_SCL_FRAC 7'h40
`define CFC_SCL_INT 7'h00
`define CFC_SCL_H_DEN 7'h18

`endif

// ### verilog/cfc_int2flt.v
// Purpose: Unsigned magnitude to single float, nearest even
// Assumes: Magnitude is a value times two to the minus scale
// Notes: Purely combinational
`timescale 1ns/1ps
`include "cfc_defs.vh"

module cfc_int2flt
(
   input wire [63:0] mag,
   input wire sticky_in,
   input wire sign,
   input wire [6:0] scale,
   output reg [31:0] result
);

   integer k; // Bit scan index
   reg [5:0] p; // Leading one position
   reg [63:0] norm; // Leading one moved to top
   reg [9:0] e; // Biased exponent
   reg g; // Guard bit
   reg st; // Sticky bit
   reg up; // Round increment

   ////////////////////////////////////////////////////////////////////////////
   // Normalize, then round half to even
   always @*
   begin
      p = 6'h00;
      for (k = 0; k < 64; k = k + 1)
      begin
         if (mag[k])
         begin
            p = k[5:0];
         end
      end
      norm = mag << (6'h3F - p);
      g = norm[39];
      st = (|norm[38:0]) | sticky_in;
      up = g & (st | norm[40]);
      e = `CFC_F32_BIAS + {4'h0, p} - {3'h0, scale};
      if (mag == 64'h0)
      begin
         // Zero keeps its sign
         result = {sign, 31'h0};
      end
      else
      begin
         // Mantissa carry spills into the exponent
         result = {sign, e[7:0], norm[62:40]} + {31'h0, up};
      end
   end

endmodule // cfc_int2flt

// ### verilog/cfc_f32to16.v
// Purpose: Single float narrowed to half float
// Assumes: Input is a raw single float word
// Notes: Purely combinational; tiny values below denormal range flush
`timescale 1ns/1ps
`include "cfc_defs.vh"

module cfc_f32to16
(
   input wire [31:0] f,
   output reg [15:0] h
);

   reg [7:0] e; // Single exponent
   reg [7:0] shf; // Denormal shift count
   reg [33:0] mant; // Hidden one, fraction, round room
   reg [9:0] kept; // Denormal fraction before rounding
   reg g; // Guard bit
   reg st; // Sticky bit
   reg [7:0] he; // Half exponent

   ////////////////////////////////////////////////////////////////////////////
   // Classify the exponent and rebuild the half word
   always @*
   begin
      e = f[30:23];
      shf = `CFC_H_DEN_SHF - e;
      mant = {1'b1, f[22:0], 10'h000} >> shf;
      kept = mant[19:10];
      g = mant[9];
      st = |mant[8:0];
      he = e - `CFC_F16_TO_F32;
      if (e == `CFC_F32_EMAX)
      begin
         // Infinity passes, NaN stays NaN
         h = {f[31], `CFC_F16_EMAX, (f[22:0] != 23'h0) ? `CFC_F16_QNAN : 10'h000};
      end
      else if (e > `CFC_H_MAX_EXP)
      begin
         h = {f[31], `CFC_F16_EMAX, 10'h000};
      end
      else if (e >= `CFC_H_MIN_EXP)
      begin
         h = {f[31], he[4:0], f[22:13]}
            + {15'h0, f[12] & ((|f[11:0]) | f[13])};
      end
      else if (e >= `CFC_H_DEN_EXP)
      begin
         h = {f[31], 5'h00, kept} + {15'h0, g & (st | kept[0])};
      end
      else
      begin
         // Below the denormal range
         h = {f[31], 15'h0000};
      end
   end

endmodule // cfc_f32to16

// ### verilog/cfc_top.v
// Purpose: Channel format converter datapath
// Assumes: Requests come from logic on clk, one per cycle at most
// Notes: Two edges from request to result; gamma curve is power two
`timescale 1ns/1ps
`include "cfc_defs.vh"

module cfc_top
(
   input wire clk,
   input wire sys_rst,
   input wire in_valid,
   input wire [3:0] in_fmt,
   input wire [1:0] in_width,
   input wire in_gamma,
   input wire in_gamma_store,
   input wire [63:0] in_data,
   output reg out_valid,
   output reg [63:0] out_data,
   output reg [3:0] out_class,
   output reg out_unsup
);

   ////////////////////////////////////////////////////////////////////////////
   // Request stage registers
   reg v1_r; // Request held
   reg [3:0] fmt_r; // Held format
   reg [1:0] wid_r; // Held width code
   reg gam_r; // Held gamma flag
   reg gst_r; // Held gamma direction, high for store
   reg [63:0] dat_r; // Held source word

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         v1_r <= 1'b0;
         fmt_r <= 4'h0;
         wid_r <= 2'h0;
         gam_r <= 1'b0;
         gst_r <= 1'b0;
         dat_r <= 64'h0;
      end
      else
      begin
         v1_r <= in_valid;
         // Data only moves with a request
         if (in_valid)
         begin
            fmt_r <= in_fmt;
            wid_r <= in_width;
            gam_r <= in_gamma;
            gst_r <= in_gamma_store;
            dat_r <= in_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source codes by width
   wire w8 = (wid_r == `CFC_W8); // Eight-bit channel
   wire w16 = (wid_r == `CFC_W16); // Sixteen-bit channel
   wire [31:0] zx = w8 ? {24'h0, dat_r[7:0]} :
                    w16 ? {16'h0, dat_r[15:0]} : dat_r[31:0]; // Zero extended
   wire [31:0] sx = w8 ? {{24{dat_r[7]}}, dat_r[7:0]} :
                    w16 ? {{16{dat_r[15]}}, dat_r[15:0]} : dat_r[31:0]; // Sign extended
   wire neg = sx[31]; // Negative signed code
   wire [31:0] ab = neg ? (~sx + 32'h1) : sx; // Magnitude, exact for all codes
   wire [31:0] smin = w8 ? 32'hFFFFFF80 : w16 ? 32'hFFFF8000 : 32'h80000000; // Most negative
   wire clamp = (sx == smin); // Code below minus one

   ////////////////////////////////////////////////////////////////////////////
   // Gamma curves on codes of 8 and 16 bits
   wire [32:0] sq = {17'h0, zx[15:0]} * {17'h0, zx[15:0]} + {17'h0, zx[15:0]}; // Square
   wire [31:0] lin = w8 ? {24'h0, sq[15:8]} : {16'h0, sq[31:16]}; // Linear code
   wire [31:0] rad = w8 ? ({16'h0, zx[7:0], 8'h00} - zx) :
                    ({zx[15:0], 16'h0000} - zx); // Code times full scale
   reg [15:0] root; // Encoded code
   reg [15:0] tr; // Trial root
   integer b; // Root bit index

   // Bitwise square root for the encoding curve
   always @*
   begin
      root = 16'h0000;
      tr = 16'h0000;
      for (b = 15; b >= 0; b = b - 1)
      begin
         tr = root | (16'h0001 << b);
         if (({16'h0, tr} * {16'h0, tr}) <= rad)
         begin
            root = tr;
         end
      end
   end

   wire [31:0] ucode = (gam_r && !gst_r) ? lin : zx;

   ////////////////////////////////////////////////////////////////////////////
   // Repeating-pattern fractions; code over all-ones equals the code repeated
   wire [30:0] sm = ab[30:0]; // Signed magnitude bits
   wire [63:0] rep_u8; // Eight-bit pattern
   wire [63:0] rep_u16; // Sixteen-bit pattern
   wire [63:0] rep_u32; // Thirty-two-bit pattern
   wire [63:0] rep_s8; // Seven-bit pattern
   wire [63:0] rep_s16; // Fifteen-bit pattern
   wire [63:0] rep_s32; // Thirty-one-bit pattern
   genvar i;

   generate
      for (i = 0; i < 64; i = i + 1)
      begin : g_rep
         assign rep_u8[i] = ucode[7 - ((63 - i) % 8)];
         assign rep_u16[i] = ucode[15 - ((63 - i) % 16)];
         assign rep_u32[i] = ucode[31 - ((63 - i) % 32)];
         assign rep_s8[i] = sm[6 - ((63 - i) % 7)];
         assign rep_s16[i] = sm[14 - ((63 - i) % 15)];
         assign rep_s32[i] = sm[30 - ((63 - i) % 31)];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Float field views
   wire [4:0] he = dat_r[14:10]; // Half exponent
   wire [9:0] hf = dat_r[9:0]; // Half fraction
   wire [7:0] fe = dat_r[30:23]; // Single exponent
   wire [22:0] ff = dat_r[22:0]; // Single fraction
   wire [10:0] de = dat_r[62:52]; // Double exponent
   wire [51:0] df = dat_r[51:0]; // Double fraction
   wire [31:0] half_w; // Narrowed half word in low bits
   wire [15:0] half_n; // Narrowed half word

   cfc_f32to16 u_f32to16
   (
      .f(dat_r[31:0]),
      .h(half_n)
   );
   assign half_w = {16'h0, half_n};

   ////////////////////////////////////////////////////////////////////////////
   // Normalizer operand select
   reg [63:0] n_mag; // Normalizer magnitude
   reg n_stk; // Tail beyond the magnitude
   reg n_sgn; // Result sign
   reg [6:0] n_scl; // Fraction scale
   wire [31:0] flt; // Normalizer result

   always @*
   begin
      n_mag = 64'h0;
      n_stk = 1'b0;
      n_sgn = 1'b0;
      n_scl = `CFC_SCL_INT;
      case (fmt_r)
         `CFC_FMT_UNSIGNED_NORMALIZED:
         begin
            n_mag = w8 ? rep_u8 : w16 ? rep_u16 : rep_u32;
            n_stk = |ucode;
            n_scl = `CFC_SCL_FRAC;
         end
         `CFC_FMT_SIGNED_NORMALIZED:
         begin
            n_mag = w8 ? rep_s8 : w16 ? rep_s16 : rep_s32;
            n_stk = |sm;
            n_sgn = neg;
            n_scl = `CFC_SCL_FRAC;
         end
         `CFC_FMT_UNSIGNED_SCALED_TO_FLOAT:
         begin
            n_mag = {32'h0, zx};
         end
         `CFC_FMT_SIGNED_SCALED_TO_FLOAT:
         begin
            n_mag = {32'h0, ab};
            n_sgn = neg;
         end
         `CFC_FMT_F16:
         begin
            n_mag = {54'h0, hf};
            n_sgn = dat_r[15];
            n_scl = `CFC_SCL_H_DEN;
         end
         default:
         begin
            n_mag = 64'h0;
         end
      endcase
   end

   cfc_int2flt u_int2flt
   (
      .mag(n_mag),
      .sticky_in(n_stk),
      .sign(n_sgn),
      .scale(n_scl),
      .result(flt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Result select and float classes {nan, inf, zero, denormal}
   reg [63:0] res_nxt; // Next result word
   reg [3:0] cls_nxt; // Next class flags
   reg uns_nxt; // Next unsupported flag
   reg [7:0] hx; // Half exponent rebased to single

   always @*
   begin
      res_nxt = 64'h0;
      cls_nxt = 4'h0;
      hx = {3'h0, he} + `CFC_F16_TO_F32;
      uns_nxt = (gam_r && ((fmt_r != `CFC_FMT_UNSIGNED_NORMALIZED) || (wid_r > `CFC_W16)))
         || (wid_r > `CFC_W32) || (fmt_r > `CFC_FMT_F32TO16);
      case (fmt_r)
         `CFC_FMT_UNSIGNED_NORMALIZED:
         begin
            if (gam_r && gst_r)
            begin
               res_nxt = {48'h0, root};
            end
            else
            begin
               res_nxt = {32'h0, flt};
            end
         end
         `CFC_FMT_SIGNED_NORMALIZED:
         begin
            res_nxt = {32'h0, clamp ? `CFC_NEG_ONE : flt};
         end
         `CFC_FMT_UNSIGNED_INTEGER_COPY:
         begin
            res_nxt = {32'h0, zx};
         end
         `CFC_FMT_SIGNED_INTEGER_COPY:
         begin
            res_nxt = {{32{sx[31]}}, sx};
         end
         `CFC_FMT_UNSIGNED_SCALED_TO_FLOAT, `CFC_FMT_SIGNED_SCALED_TO_FLOAT:
         begin
            res_nxt = {32'h0, flt};
         end
         `CFC_FMT_F32, `CFC_FMT_F32TO16:
         begin
            res_nxt = (fmt_r == `CFC_FMT_F32) ? {32'h0, dat_r[31:0]} : {32'h0, half_w};
            cls_nxt = {(fe == `CFC_F32_EMAX) && (ff != 23'h0),
                       (fe == `CFC_F32_EMAX) && (ff == 23'h0),
                       (fe == 8'h00) && (ff == 23'h0),
                       (fe == 8'h00) && (ff != 23'h0)};
         end
         `CFC_FMT_F64:
         begin
            res_nxt = dat_r;
            cls_nxt = {(de == `CFC_F64_EMAX) && (df != 52'h0),
                       (de == `CFC_F64_EMAX) && (df == 52'h0),
                       (de == 11'h000) && (df == 52'h0),
                       (de == 11'h000) && (df != 52'h0)};
         end
         `CFC_FMT_F16:
         begin
            cls_nxt = {(he == `CFC_F16_EMAX) && (hf != 10'h0),
                       (he == `CFC_F16_EMAX) && (hf == 10'h0),
                       (he == 5'h00) && (hf == 10'h0),
                       (he == 5'h00) && (hf != 10'h0)};
            if (he == `CFC_F16_EMAX)
            begin
               // Infinity, or a quiet NaN
               res_nxt = {32'h0, dat_r[15], `CFC_F32_EMAX,
                          (hf != 10'h0) ? `CFC_F32_QNAN : 23'h0};
            end
            else if (he == 5'h00)
            begin
               // Denormal or signed zero through the normalizer
               res_nxt = {32'h0, flt};
            end
            else
            begin
               res_nxt = {32'h0, dat_r[15], hx, hf, 13'h0000};
            end
         end
         default:
         begin
            res_nxt = 64'h0;
         end
      endcase
      // Unsupported requests give zero
      if (uns_nxt)
      begin
         res_nxt = 64'h0;
         cls_nxt = 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // result stage with valid
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         out_valid <= 1'b0;
         out_data <= 64'h0;
         out_class <= 4'h0;
         out_unsup <= 1'b0;
      end
      else
      begin
         out_valid <= v1_r;
         // Outputs hold between results
         if (v1_r)
         begin
            out_data <= res_nxt;
            out_class <= cls_nxt;
            out_unsup <= uns_nxt;
         end
      end
   end

endmodule // cfc_top

// ### sim/cfc_top_checker.sv
// Purpose: Port-level checker of the channel format converter
// Assumes: Result flag rises two edges after a taken request
// Notes: Results are looked at two sampling edges after the taking edge
`timescale 1ns/1ps

module cfc_top_checker
(
   input wire clk,
   input wire sys_rst,
   input wire in_valid,
   input wire [3:0] in_fmt,
   input wire [1:0] in_width,
   input wire in_gamma,
   input wire in_gamma_store,
   input wire [63:0] in_data,
   input wire out_valid,
   input wire [63:0] out_data,
   input wire [3:0] out_class,
   input wire out_unsup
);
   // All checks on the one clock, quiet in reset except the reset check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   valid_lat_a: assert property (in_valid |-> ##2 out_valid)
      else $error("result flag late or missing");
   no_spur_a: assert property (out_valid |-> $past(in_valid, 2) && !$past(sys_rst, 2))
      else $error("result flag without request");
   rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> !out_valid
      && out_data == 64'h0 && out_class == 4'h0 && !out_unsup) else $error("reset left outputs");
   res_hold_a: assert property (!out_valid && !$past(sys_rst) |-> $stable(out_data)
      && $stable(out_class) && $stable(out_unsup)) else $error("result changed between results");
   bad_fmt_a: assert property (in_valid && (in_fmt > 4'h9 || (in_fmt < 4'h6
      && in_width == 2'h3)) |-> ##2 out_unsup && out_data == 64'h0) else $error("bad code taken");
   gamma_only_a: assert property (in_valid && in_gamma && in_fmt != 4'h0 |-> ##2 out_unsup)
      else $error("gamma accepted off unsigned normalized");
   unsigned_normalized_one_a: assert property (in_valid && in_fmt == 4'h0 && in_width == 2'h0 && !in_gamma
      && in_data[7:0] == 8'hFF |-> ##2 out_data == 64'h3F800000) else $error("all ones not one");
   signed_normalized_clamp_a: assert property (in_valid && in_fmt == 4'h1 && in_width == 2'h0 && !in_gamma
      && in_data[7:0] == 8'h80 |-> ##2 out_data == 64'hBF800000) else $error("no clamp");
   signed_integer_copy_ext_a: assert property (in_valid && in_fmt == 4'h4 && in_width == 2'h0 && !in_gamma
      |-> ##2 out_data == {{56{$past(in_data[7], 2)}}, $past(in_data[7:0], 2)})
      else $error("signed copy not extended");
   unsigned_integer_copy_zext_a: assert property (in_valid && in_fmt == 4'h2 && in_width == 2'h1 && !in_gamma
      |-> ##2 out_data == {48'h0, $past(in_data[15:0], 2)}) else $error("unsigned copy wrong");
   half_inf_a: assert property (in_valid && in_fmt == 4'h9 && in_data[30:23] > 8'h8E
      && in_data[30:23] != 8'hFF |-> ##2 out_data == {48'h0, $past(in_data[31], 2), 15'h7C00})
      else $error("large exponent not half infinity");
endmodule // cfc_top_checker

// ### sim/cfc_src_model.sv
// Purpose: Request source standing in for sampler and render units
// Assumes: Called by the bench just after a falling edge
// Notes: Released lines show inverted values, never the last request
`timescale 1ns/1ps

module cfc_src_model
(
   output logic in_valid,
   output logic [3:0] in_fmt,
   output logic [1:0] in_width,
   output logic in_gamma,
   output logic in_gamma_store,
   output logic [63:0] in_data
);
   // Idle lines at time zero
   initial
   begin
      in_valid = 1'b0;
      {in_fmt, in_width, in_gamma, in_gamma_store, in_data} = '0;
   end

   task put(input logic [3:0] f, input logic [1:0] w, input logic g, input logic s,
      input logic [63:0] d);
      in_valid = 1'b1;
      in_fmt = f;
      in_width = w;
      in_gamma = g;
      in_gamma_store = s;
      in_data = d;
   endtask

   // Released qualifiers flip so stale values cannot pass
   task idle;
      in_valid = 1'b0;
      {in_fmt, in_width, in_gamma, in_gamma_store} = ~{in_fmt, in_width, in_gamma, in_gamma_store};
      in_data = ~in_data;
   endtask
endmodule // cfc_src_model

// ### sim/cfc_top_test.sv
// Purpose: Self-checking bench of the channel format converter
// Assumes: Fixed two-edge latency; inputs change on the falling edge
// Notes: Expected words are worked by hand from the format rules
`timescale 1ns/1ps

module cfc_top_test;
   logic clk = 1'b0; // 25 MHz clock
   logic sys_rst = 1'b1; // Synchronous reset, held at start
   wire in_valid;
   wire [3:0] in_fmt;
   wire [1:0] in_width;
   wire in_gamma;
   wire in_gamma_store;
   wire [63:0] in_data;
   wire out_valid;
   wire [63:0] out_data;
   wire [3:0] out_class;
   wire out_unsup;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0; // Cycle count for the hang guard

   always #20 clk = ~clk;

   cfc_top u_cfc_top (.clk(clk), .sys_rst(sys_rst), .in_valid(in_valid), .in_fmt(in_fmt),
      .in_width(in_width), .in_gamma(in_gamma), .in_gamma_store(in_gamma_store),
      .in_data(in_data), .out_valid(out_valid), .out_data(out_data), .out_class(out_class),
      .out_unsup(out_unsup));
   cfc_src_model u_cfc_src_model (.in_valid(in_valid), .in_fmt(in_fmt), .in_width(in_width),
      .in_gamma(in_gamma), .in_gamma_store(in_gamma_store), .in_data(in_data));

   // Verdict and end of run
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         err_count++;
         end_of_test;
      end
   end

   task check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task send(input logic [3:0] f, input logic [1:0] w, input logic g, input logic s,
      input logic [63:0] d);
      @(negedge clk);
      u_cfc_src_model.put(f, w, g, s, d);
   endtask

   // Judge the result standing now
   task expect_now(input logic [63:0] ed, input logic [3:0] ec, input logic eu);
      check(out_valid, 1'b1);
      check(out_data, ed);
      check(out_class, ec);
      check(out_unsup, eu);
   endtask

   // Judge the result one falling edge later
   task expect_out(input logic [63:0] ed, input logic [3:0] ec, input logic eu);
      @(negedge clk);
      expect_now(ed, ec, eu);
   endtask

   task xfer(input logic [3:0] f, input logic [1:0] w, input logic g, input logic s,
      input logic [63:0] d, input logic [63:0] ed, input logic [3:0] ec, input logic eu);
      send(f, w, g, s, d);
      @(negedge clk);
      u_cfc_src_model.idle;
      expect_out(ed, ec, eu);
   endtask

   task xp(input logic [3:0] f, input logic [1:0] w, input logic [63:0] d,
      input logic [63:0] ed, input logic [3:0] ec);
      xfer(f, w, 1'b0, 1'b0, d, ed, ec, 1'b0);
   endtask

   task t_norm;
      xp(4'h0, 2'h0, 8'hFF, 32'h3F800000, 4'h0);
      xp(4'h0, 2'h0, 8'h80, 32'h3F008081, 4'h0);
      xp(4'h0, 2'h2, 32'hFFFFFFFF, 32'h3F800000, 4'h0);
      xp(4'h1, 2'h0, 8'h40, 32'h3F010204, 4'h0);
      xp(4'h1, 2'h0, 8'h81, 32'hBF800000, 4'h0);
      xp(4'h1, 2'h0, 8'h80, 32'hBF800000, 4'h0);
      xp(4'h1, 2'h1, 16'h8000, 32'hBF800000, 4'h0);
   endtask

   task t_gamma;
      xfer(4'h0, 2'h0, 1'b1, 1'b0, 8'h80, 32'h3E808081, 4'h0, 1'b0);
      xfer(4'h0, 2'h0, 1'b1, 1'b1, 8'h40, 8'h7F, 4'h0, 1'b0);
      xfer(4'h1, 2'h0, 1'b1, 1'b0, 8'h40, 64'h0, 4'h0, 1'b1);
      xfer(4'hA, 2'h0, 1'b0, 1'b0, 8'h12, 64'h0, 4'h0, 1'b1);
      xfer(4'h0, 2'h3, 1'b0, 1'b0, 8'h12, 64'h0, 4'h0, 1'b1);
   endtask

   task t_int;
      xp(4'h2, 2'h1, 16'hFFFF, 16'hFFFF, 4'h0);
      xp(4'h2, 2'h2, 32'hFFFFFFFF, 32'hFFFFFFFF, 4'h0);
      xp(4'h3, 2'h2, 32'h01000003, 32'h4B800002, 4'h0);
      xp(4'h3, 2'h2, 32'hFFFFFFFF, 32'h4F800000, 4'h0);
      xp(4'h4, 2'h2, 32'h80000000, 64'hFFFFFFFF80000000, 4'h0);
      xp(4'h5, 2'h2, 32'hFFFFFFFD, 32'hC0400000, 4'h0);
      xp(4'h5, 2'h2, 32'h80000001, 32'hCF000000, 4'h0);
   endtask

   task t_float;
      xp(4'h6, 2'h0, 32'hFF800000, 32'hFF800000, 4'h4);
      xp(4'h6, 2'h0, 32'hFFC00000, 32'hFFC00000, 4'h8);
      xp(4'h6, 2'h0, 32'h00000001, 32'h00000001, 4'h1);
      xp(4'h7, 2'h0, 64'hFFF0000000000000, 64'hFFF0000000000000, 4'h4);
      xp(4'h7, 2'h0, 64'h8000000000000000, 64'h8000000000000000, 4'h2);
      xp(4'h8, 2'h0, 16'h0001, 32'h33800000, 4'h1);
      xp(4'h8, 2'h0, 16'h7E00, 32'h7FC00000, 4'h8);
      xp(4'h8, 2'h0, 16'h3C00, 32'h3F800000, 4'h0);
   endtask

   task t_narrow;
      xp(4'h9, 2'h0, 32'h477FE000, 16'h7BFF, 4'h0);
      xp(4'h9, 2'h0, 32'hC7800000, 16'hFC00, 4'h0);
      xp(4'h9, 2'h0, 32'h38800000, 16'h0400, 4'h0);
      xp(4'h9, 2'h0, 32'h38000000, 16'h0200, 4'h0);
      xp(4'h9, 2'h0, 32'h33800000, 16'h0001, 4'h0);
      xp(4'h9, 2'h0, 32'h3F801000, 16'h3C00, 4'h0);
      xp(4'h9, 2'h0, 32'h3F803000, 16'h3C02, 4'h0);
   endtask

   // back to back requests, result holds
   task t_b2b;
      send(4'h3, 2'h0, 1'b0, 1'b0, 8'h03);
      send(4'h4, 2'h0, 1'b0, 1'b0, 8'hFD);
      @(negedge clk);
      u_cfc_src_model.idle;
      expect_now(32'h40400000, 4'h0, 1'b0);
      expect_out(64'hFFFFFFFFFFFFFFFD, 4'h0, 1'b0);
      @(negedge clk);
      check(out_valid, 1'b0);
      check(out_data, 64'hFFFFFFFFFFFFFFFD);
   endtask

   // reset drops a request in flight
   task t_reset;
      send(4'h0, 2'h0, 1'b0, 1'b0, 8'hFF);
      @(negedge clk);
      u_cfc_src_model.idle;
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      check(out_valid, 1'b0);
      check(out_data, 64'h0);
      @(negedge clk);
      check(out_valid, 1'b0);
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      t_norm;
      t_gamma;
      t_int;
      t_float;
      t_narrow;
      t_b2b;
      t_reset;
      end_of_test;
   end
endmodule // cfc_top_test

bind cfc_top cfc_top_checker u_cfc_top_checker (.clk(clk), .sys_rst(sys_rst),
   .in_valid(in_valid), .in_fmt(in_fmt), .in_width(in_width), .in_gamma(in_gamma),
   .in_gamma_store(in_gamma_store), .in_data(in_data), .out_valid(out_valid),
   .out_data(out_data), .out_class(out_class), .out_unsup(out_unsup));
